// >>> common/ext_mem_op_pkg.sv
// ============================================================
// Shared widths, layouts, resets and encodings
package ext_mem_op_pkg;

	// ========================================================
	// Widths
	localparam int DATA_W   = 8;   // Data memory byte
	localparam int DADDR_W  = 10;  // Data memory address
	localparam int PDATA_W  = 16;  // Program word
	localparam int PADDR_W  = 14;  // Program memory address
	localparam int PAGE_W   = 6;   // Page bits above the low pointer
	localparam int BITSEL_W = 3;   // Bit index within a byte

	// ========================================================
	// Field positions
	localparam int SIGN_BIT = 7;   // Sign bit of a byte
	localparam int NIB_LO   = 0;   // Low nibble base
	localparam int NIB_HI   = 4;   // High nibble base
	localparam int NIB_W    = 4;   // Nibble width
	localparam int LOW_LSB  = 0;   // Program word low byte base
	localparam int HIGH_LSB = 8;   // Program word high byte base

	// ========================================================
	// Constant values and reset values
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] BYTE_ONE  = 8'h01;
	localparam logic [PAGE_W-1:0] LAST_PAGE = 6'h3F;
	localparam logic [DATA_W-1:0] WORK_RST  = 8'h00;
	localparam logic [DATA_W-1:0] PTR_RST   = 8'h00;
	localparam logic [DATA_W-1:0] LATCH_RST = 8'h00;
	localparam logic              FLAG_RST  = 1'b0;

	// ========================================================
	// Operations handled by the executor
	typedef enum logic [3:0] {
		OP_INC_SKIP_ZERO_TO_WORK = 4'h0,
		OP_SKIP_IF_BIT_NONZERO   = 4'h1,
		OP_SKIP_IF_BIT_ZERO      = 4'h2,
		OP_SKIP_IF_NONZERO       = 4'h3,
		OP_SKIP_IF_ZERO          = 4'h4,
		OP_LOAD_SKIP_IF_ZERO     = 4'h5,
		OP_SUBTRACT_TO_WORK      = 4'h6,
		OP_SUBTRACT_TO_MEMORY    = 4'h7,
		OP_NIBBLE_EXCHANGE       = 4'h8,
		OP_NIBBLE_EXCHANGE_WORK  = 4'h9,
		OP_PAGED_TABLE_READ      = 4'hA,
		OP_LAST_PAGE_TABLE_READ  = 4'hB,
		OP_PREINC_PAGED_READ     = 4'hC,
		OP_PREINC_LAST_PAGE_READ = 4'hD,
		OP_EXCLUSIVE_OR_TO_WORK  = 4'hE,
		OP_EXCLUSIVE_OR_TO_MEM   = 4'hF
	} op_e;

	// ========================================================
	// Sequencer states, one bit flips per step except EXEC and FILL back to IDLE
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_READ  = 3'h1,
		ST_EXEC  = 3'h3,
		ST_DUMMY = 3'h2,
		ST_PROG  = 3'h4,
		ST_FILL  = 3'h5
	} state_e;

endpackage : ext_mem_op_pkg

// >>> core/sub_flag_unit.sv
`timescale 1ns/1ps
// ============================================================
// Byte subtractor with the full status flag set
module sub_flag_unit (
	input  wire logic [ext_mem_op_pkg::DATA_W-1:0] minuend,
	input  wire logic [ext_mem_op_pkg::DATA_W-1:0] subtrahend,
	output logic [ext_mem_op_pkg::DATA_W-1:0]      difference,
	output logic                                   signedRangeFlag,
	output logic                                   zeroFlag,
	output logic                                   nibbleBorrowFlag,
	output logic                                   borrowFlag,
	output logic                                   signedCompareFlag,
	output logic                                   chainedNullFlag
);

	// ========================================================
	// Arithmetic
	logic [ext_mem_op_pkg::DATA_W:0] wideDiff;  // Extra bit is the borrow
	logic                            minSign;   // Sign of minuend
	logic                            subSign;   // Sign of subtrahend
	logic                            difSign;   // Sign of result

	assign wideDiff   = {1'b0, minuend} - {1'b0, subtrahend};
	assign difference = wideDiff[ext_mem_op_pkg::DATA_W-1:0];
	assign minSign    = minuend[ext_mem_op_pkg::SIGN_BIT];
	assign subSign    = subtrahend[ext_mem_op_pkg::SIGN_BIT];
	assign difSign    = difference[ext_mem_op_pkg::SIGN_BIT];

	// ========================================================
	// Flags: carry sense is inverted, set means no borrow
	assign borrowFlag       = ~wideDiff[ext_mem_op_pkg::DATA_W];
	assign nibbleBorrowFlag =
		minuend[ext_mem_op_pkg::NIB_LO +: ext_mem_op_pkg::NIB_W] >=
		subtrahend[ext_mem_op_pkg::NIB_LO +: ext_mem_op_pkg::NIB_W];
	// Overflow only when operand signs differ and result flips
	assign signedRangeFlag  = (minSign ^ subSign) & (minSign ^ difSign);
	assign zeroFlag         = difference == ext_mem_op_pkg::BYTE_ZERO;
	// True signed less-than, immune to overflow
	assign signedCompareFlag = signedRangeFlag ^ difSign;
	// No incoming carry here, so the chained test equals zero
	assign chainedNullFlag  = zeroFlag;

endmodule : sub_flag_unit

// >>> core/extended_memory_op_executor.sv
`timescale 1ns/1ps
// ============================================================
// Extended data memory operation executor
// What this block does
// - Increment byte into work, skip on zero
// - Taken skip costs three cycles, else continue
// - Bit test skips when selected bit one
// - Bit test skips when selected bit zero
// - Byte tests write back, skip zero/nonzero
// - Work minus byte; carry set unless negative
// - Subtracts update all six status flags
// - Subtract variant writes difference to memory
// - Swap byte nibbles in place, no flags
// - Swapped byte to work, memory unchanged
// - Copy byte to work, skip on zero
// - Paged table read: low memory, high latch
// - Last page table read uses low pointer
// - Pre-increment low pointer, then paged read
// - Pre-increment low pointer, then last page
// - Exclusive-or into work, zero flag only
// - Exclusive-or into memory, zero flag only
module extended_memory_op_executor (
	input  wire logic                                clk_sys,
	input  wire logic                                rst_b,
	input  wire logic                                clkEn,
	input  wire logic                                opStart,
	input  wire ext_mem_op_pkg::op_e                 opCode,
	input  wire logic [ext_mem_op_pkg::DADDR_W-1:0]  opAddr,
	input  wire logic [ext_mem_op_pkg::BITSEL_W-1:0] opBit,
	output logic                                     ready,
	output logic                                     opDone,
	output logic                                     skipNext,
	output logic [ext_mem_op_pkg::DADDR_W-1:0]       memAddr,
	output logic                                     memRd,
	input  wire logic [ext_mem_op_pkg::DATA_W-1:0]   memRdData,
	output logic                                     memWr,
	output logic [ext_mem_op_pkg::DATA_W-1:0]        memWrData,
	output logic [ext_mem_op_pkg::PADDR_W-1:0]       progAddr,
	output logic                                     progRd,
	input  wire logic [ext_mem_op_pkg::PDATA_W-1:0]  progData,
	input  wire logic                                ptrLowWr,
	input  wire logic                                ptrHighWr,
	input  wire logic [ext_mem_op_pkg::DATA_W-1:0]   ptrWrData,
	input  wire logic                                workLoad,
	input  wire logic [ext_mem_op_pkg::DATA_W-1:0]   workLoadData,
	output logic [ext_mem_op_pkg::DATA_W-1:0]        workRegister,
	output logic                                     signedRangeFlag,
	output logic                                     zeroFlag,
	output logic                                     nibbleBorrowFlag,
	output logic                                     borrowFlag,
	output logic                                     signedCompareFlag,
	output logic                                     chainedNullFlag,
	output logic [ext_mem_op_pkg::DATA_W-1:0]        tableHighLatch,
	output logic [ext_mem_op_pkg::DATA_W-1:0]        tablePtrLow,
	output logic [ext_mem_op_pkg::DATA_W-1:0]        tablePtrHigh
);

	// ========================================================
	// Sequencer and captured operation
	ext_mem_op_pkg::state_e                  state;      // Current step
	ext_mem_op_pkg::state_e                  next_state; // Following step
	ext_mem_op_pkg::op_e                     opQ;        // Held operation
	logic [ext_mem_op_pkg::BITSEL_W-1:0]     bitQ;       // Held bit index
	logic [ext_mem_op_pkg::DADDR_W-1:0]      addrQ;      // Held address

	// ========================================================
	// Operation classes
	logic tableOp;     // Any of the four table reads
	logic preincOp;    // Table read that bumps the low pointer
	logic lastPageOp;  // Table read fixed to the final page
	logic subOp;       // Either subtract form
	logic xorOp;       // Either exclusive-or form
	logic workWrite;   // Result lands in the work register
	logic memWrite;    // Result lands in data memory
	logic takeSkip;    // Skip condition met in execute step

	assign tableOp = opQ inside {
		ext_mem_op_pkg::OP_PAGED_TABLE_READ,
		ext_mem_op_pkg::OP_LAST_PAGE_TABLE_READ,
		ext_mem_op_pkg::OP_PREINC_PAGED_READ,
		ext_mem_op_pkg::OP_PREINC_LAST_PAGE_READ};
	assign preincOp = opQ inside {
		ext_mem_op_pkg::OP_PREINC_PAGED_READ,
		ext_mem_op_pkg::OP_PREINC_LAST_PAGE_READ};
	assign lastPageOp = opQ inside {
		ext_mem_op_pkg::OP_LAST_PAGE_TABLE_READ,
		ext_mem_op_pkg::OP_PREINC_LAST_PAGE_READ};
	assign subOp = opQ inside {
		ext_mem_op_pkg::OP_SUBTRACT_TO_WORK,
		ext_mem_op_pkg::OP_SUBTRACT_TO_MEMORY};
	assign xorOp = opQ inside {
		ext_mem_op_pkg::OP_EXCLUSIVE_OR_TO_WORK,
		ext_mem_op_pkg::OP_EXCLUSIVE_OR_TO_MEM};
	assign workWrite = opQ inside {
		ext_mem_op_pkg::OP_INC_SKIP_ZERO_TO_WORK,
		ext_mem_op_pkg::OP_LOAD_SKIP_IF_ZERO,
		ext_mem_op_pkg::OP_SUBTRACT_TO_WORK,
		ext_mem_op_pkg::OP_NIBBLE_EXCHANGE_WORK,
		ext_mem_op_pkg::OP_EXCLUSIVE_OR_TO_WORK};
	// Byte tests rewrite the byte they read
	assign memWrite = opQ inside {
		ext_mem_op_pkg::OP_SKIP_IF_NONZERO,
		ext_mem_op_pkg::OP_SKIP_IF_ZERO,
		ext_mem_op_pkg::OP_SUBTRACT_TO_MEMORY,
		ext_mem_op_pkg::OP_NIBBLE_EXCHANGE,
		ext_mem_op_pkg::OP_EXCLUSIVE_OR_TO_MEM};

	// ========================================================
	// Datapath
	logic [ext_mem_op_pkg::DATA_W-1:0] incByte;  // Byte plus one
	logic [ext_mem_op_pkg::DATA_W-1:0] swapByte; // Nibbles exchanged
	logic [ext_mem_op_pkg::DATA_W-1:0] xorByte;  // Work xor byte
	logic [ext_mem_op_pkg::DATA_W-1:0] subByte;  // Work minus byte
	logic [ext_mem_op_pkg::DATA_W-1:0] result;   // Selected result
	logic                              selBit;   // Tested bit
	logic                              memZero;  // Byte is zero
	logic subOv, subZ, subAc, subC, subSc, subCz;  // Subtract flags
	logic [ext_mem_op_pkg::DATA_W-1:0] ptrLowRead; // Low pointer as fetched

	assign incByte  = memRdData + ext_mem_op_pkg::BYTE_ONE;
	assign swapByte = {
		memRdData[ext_mem_op_pkg::NIB_LO +: ext_mem_op_pkg::NIB_W],
		memRdData[ext_mem_op_pkg::NIB_HI +: ext_mem_op_pkg::NIB_W]};
	assign xorByte  = workRegister ^ memRdData;
	assign selBit   = memRdData[bitQ];
	assign memZero  = memRdData == ext_mem_op_pkg::BYTE_ZERO;

	// Result selection; byte tests and loads pass the byte through
	assign result =
		(opQ == ext_mem_op_pkg::OP_INC_SKIP_ZERO_TO_WORK) ? incByte :
		subOp ? subByte :
		xorOp ? xorByte :
		(opQ == ext_mem_op_pkg::OP_NIBBLE_EXCHANGE ||
		 opQ == ext_mem_op_pkg::OP_NIBBLE_EXCHANGE_WORK) ? swapByte :
		memRdData;

	// Skip condition per test kind
	assign takeSkip =
		(opQ == ext_mem_op_pkg::OP_INC_SKIP_ZERO_TO_WORK) ?
			incByte == ext_mem_op_pkg::BYTE_ZERO :
		(opQ == ext_mem_op_pkg::OP_SKIP_IF_BIT_NONZERO) ? selBit :
		(opQ == ext_mem_op_pkg::OP_SKIP_IF_BIT_ZERO) ? !selBit :
		(opQ == ext_mem_op_pkg::OP_SKIP_IF_NONZERO) ? !memZero :
		(opQ == ext_mem_op_pkg::OP_SKIP_IF_ZERO ||
		 opQ == ext_mem_op_pkg::OP_LOAD_SKIP_IF_ZERO) ? memZero :
		1'b0;

	// Shared subtractor for both subtract forms
	sub_flag_unit subUnit (
		.minuend           (workRegister),
		.subtrahend        (memRdData),
		.difference        (subByte),
		.signedRangeFlag   (subOv),
		.zeroFlag          (subZ),
		.nibbleBorrowFlag  (subAc),
		.borrowFlag        (subC),
		.signedCompareFlag (subSc),
		.chainedNullFlag   (subCz)
	);

	// ========================================================
	// Handshake and memory control
	assign ready    = state == ext_mem_op_pkg::ST_IDLE && !memWr;
	assign memRd    = state == ext_mem_op_pkg::ST_READ;
	assign progRd   = state == ext_mem_op_pkg::ST_PROG;
	assign memAddr  = addrQ;
	// The core turns its fetched instruction into a nop here
	assign skipNext = state == ext_mem_op_pkg::ST_DUMMY;
	assign opDone   = skipNext || state == ext_mem_op_pkg::ST_FILL ||
		(state == ext_mem_op_pkg::ST_EXEC && !takeSkip);
	// The bump lands only as PROG ends, so the fetch adds it itself
	assign ptrLowRead = preincOp ?
		tablePtrLow + ext_mem_op_pkg::BYTE_ONE : tablePtrLow;
	assign progAddr = lastPageOp ?
		{ext_mem_op_pkg::LAST_PAGE, ptrLowRead} :
		{tablePtrHigh[ext_mem_op_pkg::PAGE_W-1:0], ptrLowRead};

	// ========================================================
	// Next-state selection
	always_comb begin
		next_state = state;
		case (state)
			// Table reads skip the data read entirely
			ext_mem_op_pkg::ST_IDLE: begin
				if (opStart && ready) begin
					next_state = (opCode inside {
						ext_mem_op_pkg::OP_PAGED_TABLE_READ,
						ext_mem_op_pkg::OP_LAST_PAGE_TABLE_READ,
						ext_mem_op_pkg::OP_PREINC_PAGED_READ,
						ext_mem_op_pkg::OP_PREINC_LAST_PAGE_READ}) ?
						ext_mem_op_pkg::ST_PROG : ext_mem_op_pkg::ST_READ;
				end
			end
			ext_mem_op_pkg::ST_READ: begin
				next_state = ext_mem_op_pkg::ST_EXEC;
			end
			// A taken skip inserts the dummy cycle
			ext_mem_op_pkg::ST_EXEC: begin
				next_state = takeSkip ? ext_mem_op_pkg::ST_DUMMY :
					ext_mem_op_pkg::ST_IDLE;
			end
			ext_mem_op_pkg::ST_PROG: begin
				next_state = ext_mem_op_pkg::ST_FILL;
			end
			default: begin
				next_state = ext_mem_op_pkg::ST_IDLE;
			end
		endcase
	end

	// ========================================================
	// Sequencer and operand capture
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state <= ext_mem_op_pkg::ST_IDLE;
			opQ   <= ext_mem_op_pkg::OP_INC_SKIP_ZERO_TO_WORK;
			bitQ  <= '0;
			addrQ <= '0;
		end else if (clkEn) begin
			state <= next_state;
			if (opStart && ready) begin
				opQ   <= opCode;
				bitQ  <= opBit;
				addrQ <= opAddr;
			end
		end
	end

	// ========================================================
	// Data memory write port, one cycle after the result step
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			memWr     <= 1'b0;
			memWrData <= ext_mem_op_pkg::BYTE_ZERO;
		end else if (clkEn) begin
			memWr <= (state == ext_mem_op_pkg::ST_EXEC && memWrite) ||
				state == ext_mem_op_pkg::ST_FILL;
			if (state == ext_mem_op_pkg::ST_EXEC) begin
				memWrData <= result;
			end else if (state == ext_mem_op_pkg::ST_FILL) begin
				memWrData <= progData[ext_mem_op_pkg::LOW_LSB +:
					ext_mem_op_pkg::DATA_W];
			end
		end
	end

	// ========================================================
	// Work register; skipped instructions never reach it
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			workRegister <= ext_mem_op_pkg::WORK_RST;
		end else if (clkEn) begin
			if (state == ext_mem_op_pkg::ST_EXEC && workWrite) begin
				workRegister <= result;
			end else if (workLoad && state == ext_mem_op_pkg::ST_IDLE) begin
				workRegister <= workLoadData;
			end
		end
	end

	// ========================================================
	// Status flags; swap, tests and table reads leave them
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			signedRangeFlag   <= ext_mem_op_pkg::FLAG_RST;
			zeroFlag          <= ext_mem_op_pkg::FLAG_RST;
			nibbleBorrowFlag  <= ext_mem_op_pkg::FLAG_RST;
			borrowFlag        <= ext_mem_op_pkg::FLAG_RST;
			signedCompareFlag <= ext_mem_op_pkg::FLAG_RST;
			chainedNullFlag   <= ext_mem_op_pkg::FLAG_RST;
		end else if (clkEn && state == ext_mem_op_pkg::ST_EXEC) begin
			if (subOp) begin
				signedRangeFlag   <= subOv;
				zeroFlag          <= subZ;
				nibbleBorrowFlag  <= subAc;
				borrowFlag        <= subC;
				signedCompareFlag <= subSc;
				chainedNullFlag   <= subCz;
			end else if (xorOp) begin
				zeroFlag <= xorByte == ext_mem_op_pkg::BYTE_ZERO;
			end
		end
	end

	// ========================================================
	// Table pointer and high latch
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tablePtrLow    <= ext_mem_op_pkg::PTR_RST;
			tablePtrHigh   <= ext_mem_op_pkg::PTR_RST;
			tableHighLatch <= ext_mem_op_pkg::LATCH_RST;
		end else if (clkEn) begin
			// Bump wins over a core write landing in the same cycle
			if (state == ext_mem_op_pkg::ST_PROG && preincOp) begin
				tablePtrLow <= tablePtrLow + ext_mem_op_pkg::BYTE_ONE;
			end else if (ptrLowWr) begin
				tablePtrLow <= ptrWrData;
			end
			if (ptrHighWr) begin
				tablePtrHigh <= ptrWrData;
			end
			if (state == ext_mem_op_pkg::ST_FILL) begin
				tableHighLatch <= progData[ext_mem_op_pkg::HIGH_LSB +:
					ext_mem_op_pkg::DATA_W];
			end
		end
	end

	// ========================================================
	// Checks, sampled only on enabled edges
	default clocking cb @(posedge clk_sys iff clkEn); endclocking
	default disable iff (!rst_b);

	sequence skipTail;
		state == ext_mem_op_pkg::ST_DUMMY ##1 state == ext_mem_op_pkg::ST_IDLE;
	endsequence
	sequence tableFetch;
		state == ext_mem_op_pkg::ST_PROG ##1 state == ext_mem_op_pkg::ST_FILL;
	endsequence

	skip_three_cycles_a: assert property (
		state == ext_mem_op_pkg::ST_READ ##1 takeSkip |=> skipTail)
		else $error("taken skip did not add one dummy cycle");
	inc_skip_work_a: assert property (
		state == ext_mem_op_pkg::ST_EXEC &&
		opQ == ext_mem_op_pkg::OP_INC_SKIP_ZERO_TO_WORK |=>
		workRegister == $past(incByte) && !memWr &&
		skipNext == ($past(incByte) == ext_mem_op_pkg::BYTE_ZERO))
		else $error("increment skip result or skip wrong");
	bit_tests_a: assert property (
		state == ext_mem_op_pkg::ST_EXEC && (opQ ==
		ext_mem_op_pkg::OP_SKIP_IF_BIT_NONZERO) |=> skipNext == $past(selBit))
		else $error("bit nonzero test skip wrong");
	bit_zero_a: assert property (
		state == ext_mem_op_pkg::ST_EXEC && (opQ ==
		ext_mem_op_pkg::OP_SKIP_IF_BIT_ZERO) |=> skipNext != $past(selBit))
		else $error("bit zero test skip wrong");
	byte_writeback_a: assert property (
		state == ext_mem_op_pkg::ST_EXEC && (opQ inside {
		ext_mem_op_pkg::OP_SKIP_IF_ZERO, ext_mem_op_pkg::OP_SKIP_IF_NONZERO})
		|=> memWr && memWrData == $past(memRdData))
		else $error("byte test did not rewrite its byte");
	sub_borrow_a: assert property (
		state == ext_mem_op_pkg::ST_EXEC && subOp |=>
		borrowFlag == ($past(workRegister) >= $past(memRdData)))
		else $error("borrow flag sense wrong");
	sub_memory_a: assert property (
		state == ext_mem_op_pkg::ST_EXEC &&
		opQ == ext_mem_op_pkg::OP_SUBTRACT_TO_MEMORY |=> memWr &&
		memWrData == $past(workRegister) - $past(memRdData) &&
		$stable(workRegister))
		else $error("subtract to memory result wrong");
	swap_place_a: assert property (
		state == ext_mem_op_pkg::ST_EXEC &&
		opQ == ext_mem_op_pkg::OP_NIBBLE_EXCHANGE |=> memWr &&
		memWrData == {$past(memRdData[3:0]), $past(memRdData[7:4])} &&
		$stable(zeroFlag) && $stable(borrowFlag))
		else $error("nibble exchange wrong");
	table_latch_a: assert property (
		tableFetch |=> tableHighLatch == $past(progData[15:8]) &&
		memWr && memWrData == $past(progData[7:0]))
		else $error("table read bytes misplaced");
	xor_zero_a: assert property (
		state == ext_mem_op_pkg::ST_EXEC && xorOp |=>
		zeroFlag == ($past(xorByte) == ext_mem_op_pkg::BYTE_ZERO) &&
		$stable(borrowFlag) && $stable(signedRangeFlag))
		else $error("exclusive-or flag update wrong");

endmodule : extended_memory_op_executor

// >>> test/ext_mem_partner.sv
`timescale 1ns/1ps
// ============================================================
// Data memory and program memory on the far side of the executor
module ext_mem_partner (
	input  wire logic        clk_sys,
	input  wire logic [9:0]  memAddr,
	input  wire logic        memRd,
	output logic      [7:0]  memRdData,
	input  wire logic        memWr,
	input  wire logic [7:0]  memWrData,
	input  wire logic [13:0] progAddr,
	input  wire logic        progRd,
	output logic      [15:0] progData
);
	logic [7:0] mem [1024]; // Data bytes, preset by the bench
	initial memRdData = 8'h00;
	initial progData = 16'h0000;
	// Answer one cycle after the strobe; idle lines toggle so stale data
	// never looks valid
	// Plain always: the bench presets bytes and the lines start at zero
	always @(posedge clk_sys) begin
		if (memWr) begin
			mem[memAddr] <= memWrData;
		end
		memRdData <= memRd ? mem[memAddr] : ~memRdData;
		progData <= progRd ? ({2'h0, progAddr} ^ 16'hA5C3) : ~progData;
	end
endmodule : ext_mem_partner

// >>> test/extended_memory_op_executor_tb_top.sv
`timescale 1ns/1ps
module extended_memory_op_executor_tb_top;
	// ========================================================
	// Clock, reset and stimulus signals
	logic clk_sys = 1'b0, rst_b = 1'b0, clkEn = 1'b1, opStart = 1'b0;
	logic ptrLowWr = 1'b0, ptrHighWr = 1'b0, workLoad = 1'b0;
	ext_mem_op_pkg::op_e opCode = ext_mem_op_pkg::OP_SKIP_IF_ZERO;
	logic [9:0] opAddr = 10'h000, memAddr;
	logic [2:0] opBit = 3'h0;
	logic [7:0] ptrWrData = 8'h00, workLoadData = 8'h00, memRdData;
	logic [7:0] memWrData, workRegister, tableHighLatch;
	logic [7:0] tablePtrLow, tablePtrHigh;
	logic ready, opDone, skipNext, memRd, memWr, progRd;
	logic signedRangeFlag, zeroFlag, nibbleBorrowFlag, borrowFlag;
	logic signedCompareFlag, chainedNullFlag;
	logic [13:0] progAddr;
	logic [15:0] progData;
	// Expected state kept by the bench
	int error_cnt = 0, checks = 0;
	logic [7:0] w, pl, ph, em, el, v, a;
	logic ez, ec, en, eo, es, ecz;
	always #10 clk_sys = ~clk_sys;
	extended_memory_op_executor i_dut (.clk_sys, .rst_b, .clkEn, .opStart,
		.opCode, .opAddr, .opBit, .ready, .opDone, .skipNext, .memAddr,
		.memRd, .memRdData, .memWr, .memWrData, .progAddr, .progRd,
		.progData, .ptrLowWr, .ptrHighWr, .ptrWrData, .workLoad,
		.workLoadData, .workRegister, .signedRangeFlag, .zeroFlag,
		.nibbleBorrowFlag, .borrowFlag, .signedCompareFlag,
		.chainedNullFlag, .tableHighLatch, .tablePtrLow, .tablePtrHigh);
	ext_mem_partner i_mem (.clk_sys, .memAddr, .memRd, .memRdData, .memWr,
		.memWrData, .progAddr, .progRd, .progData);
	// ========================================================
	// Comparison and verdict
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task wrap_up;
		if (error_cnt == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : wrap_up
	// ========================================================
	// One operation: predict, issue, time it, compare the results
	task run_op(input ext_mem_op_pkg::op_e c, input logic [9:0] ad,
		input logic [2:0] b);
		logic [7:0] m, r;
		logic [13:0] pa;
		logic [15:0] pw;
		logic sk;
		int n;
		m = i_mem.mem[ad];
		em = m;
		sk = 1'b0;
		case (c)
			ext_mem_op_pkg::OP_INC_SKIP_ZERO_TO_WORK: begin
				w = m + 8'h01;
				sk = (w == 8'h00);
			end
			ext_mem_op_pkg::OP_SKIP_IF_BIT_NONZERO: sk = m[b];
			ext_mem_op_pkg::OP_SKIP_IF_BIT_ZERO: sk = !m[b];
			ext_mem_op_pkg::OP_SKIP_IF_NONZERO: sk = (m != 8'h00);
			ext_mem_op_pkg::OP_SKIP_IF_ZERO: sk = (m == 8'h00);
			ext_mem_op_pkg::OP_LOAD_SKIP_IF_ZERO: begin
				w = m;
				sk = (m == 8'h00);
			end
			ext_mem_op_pkg::OP_SUBTRACT_TO_WORK,
			ext_mem_op_pkg::OP_SUBTRACT_TO_MEMORY: begin
				r = w - m;
				ec = (w >= m);
				en = (w[3:0] >= m[3:0]);
				ez = (r == 8'h00);
				eo = int'($signed(w)) - int'($signed(m)) !=
					int'($signed(r));
				es = (int'($signed(w)) < int'($signed(m)));
				ecz = ez;
				if (c == ext_mem_op_pkg::OP_SUBTRACT_TO_WORK) w = r;
				else em = r;
			end
			ext_mem_op_pkg::OP_NIBBLE_EXCHANGE: em = {m[3:0], m[7:4]};
			ext_mem_op_pkg::OP_NIBBLE_EXCHANGE_WORK: w = {m[3:0], m[7:4]};
			ext_mem_op_pkg::OP_EXCLUSIVE_OR_TO_WORK,
			ext_mem_op_pkg::OP_EXCLUSIVE_OR_TO_MEM: begin
				r = w ^ m;
				ez = (r == 8'h00);
				if (c == ext_mem_op_pkg::OP_EXCLUSIVE_OR_TO_WORK) w = r;
				else em = r;
			end
			default: begin
				// Table reads; pre-increment forms bump the low pointer first
				if (c inside {ext_mem_op_pkg::OP_PREINC_PAGED_READ,
					ext_mem_op_pkg::OP_PREINC_LAST_PAGE_READ}) pl = pl + 8'h01;
				if (c inside {ext_mem_op_pkg::OP_PAGED_TABLE_READ,
					ext_mem_op_pkg::OP_PREINC_PAGED_READ}) pa = {ph[5:0], pl};
				else pa = {6'h3F, pl};
				pw = {2'h0, pa} ^ 16'hA5C3;
				em = pw[7:0];
				el = pw[15:8];
			end
		endcase
		opStart = 1'b1;
		opCode = c;
		opAddr = ad;
		opBit = b;
		@(negedge clk_sys);
		opStart = 1'b0;
		n = 1;
		while (opDone !== 1'b1 && n < 9) begin
			@(negedge clk_sys);
			n++;
		end
		chk(16'(n), sk ? 16'h0003 : 16'h0002);
		chk({15'h0000, skipNext}, {15'h0000, sk});
		while (ready !== 1'b1 && n < 14) begin
			@(negedge clk_sys);
			n++;
		end
		chk({15'h0000, ready}, 16'h0001);
		chk({8'h00, i_mem.mem[ad]}, {8'h00, em});
		chk({8'h00, workRegister}, {8'h00, w});
		chk({10'h000, zeroFlag, borrowFlag, nibbleBorrowFlag,
			signedRangeFlag, signedCompareFlag, chainedNullFlag},
			{10'h000, ez, ec, en, eo, es, ecz});
		chk({tableHighLatch, tablePtrLow}, {el, pl});
		chk({8'h00, tablePtrHigh}, {8'h00, ph});
	endtask : run_op
	// ========================================================
	// Main sequence: reset, then random operations over every code
	initial begin
		v = 8'($urandom(32'hE435F447));
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_b = 1'b1;
		{w, pl, ph, el, ez, ec, en, eo, es, ecz} = '0;
		chk({workRegister, tableHighLatch}, 16'h0000);
		for (int i = 0; i < 400; i++) begin
			// Corner values 00 and FF mixed with random bytes
			case ($urandom_range(3))
				0: v = 8'h00;
				1: v = 8'hFF;
				default: v = 8'($urandom);
			endcase
			a = 8'($urandom_range(15));
			i_mem.mem[a] = v;
			workLoad = 1'b1;
			workLoadData = (i % 5 == 0) ? v : 8'($urandom);
			w = workLoadData;
			ptrLowWr = (i % 3 == 0);
			ptrHighWr = (i % 7 == 0);
			ptrWrData = (i % 9 == 0) ? 8'hFF : 8'($urandom);
			if (ptrLowWr) pl = ptrWrData;
			if (ptrHighWr) ph = ptrWrData;
			@(negedge clk_sys);
			{workLoad, ptrLowWr, ptrHighWr} = 3'h0;
			run_op(ext_mem_op_pkg::op_e'(i < 32 ? i % 16 : $urandom_range(15)),
				{2'h0, a}, 3'($urandom));
		end
		wrap_up();
	end
	// Watchdog sized well beyond 400 operations of a few cycles each
	initial begin
		#(400 * 16 * 20);
		error_cnt++;
		wrap_up();
	end
endmodule : extended_memory_op_executor_tb_top
